// ==== design/frs_pkg.sv ====
package frs_pkg;
	// Command codes of the registers held by this block.
	localparam logic [7:0] FRS_CMD_IN_UV_POLICY  = 8'h5A;
	localparam logic [7:0] FRS_CMD_PG_ASSERT     = 8'h5E;
	localparam logic [7:0] FRS_CMD_PG_NEGATE     = 8'h5F;
	localparam logic [7:0] FRS_CMD_TURN_ON_DELAY     = 8'h60;
	localparam logic [7:0] FRS_CMD_TURN_ON_RISE_TIME      = 8'h61;
	localparam logic [7:0] FRS_CMD_TON_LIMIT     = 8'h62;
	localparam logic [7:0] FRS_CMD_TIME_UNIT     = 8'hD2;
	// Fault policy byte layout.
	localparam int         FRS_RESP_MSB          = 7;
	localparam int         FRS_RESP_LSB          = 6;
	localparam int         FRS_RETRY_MSB         = 5;
	localparam int         FRS_RETRY_LSB         = 3;
	localparam int         FRS_UNITS_MSB         = 2;
	localparam int         FRS_UNITS_LSB         = 0;
	localparam logic [1:0] FRS_RESP_IGNORE       = 2'h0;
	localparam logic [1:0] FRS_RESP_RUN_ON       = 2'h1;
	localparam logic [1:0] FRS_RESP_DISABLE      = 2'h2;
	localparam logic [1:0] FRS_RESP_LATCH        = 2'h3;
	localparam logic [2:0] FRS_RETRY_NONE        = 3'h0;
	localparam logic [2:0] FRS_RETRY_FOREVER     = 3'h7;
	// Reset values.
	localparam logic [7:0]  FRS_RST_POLICY       = 8'h80;
	localparam logic [15:0] FRS_RST_WORD         = 16'h0000;
	localparam logic [15:0] FRS_RST_TIME_UNIT    = 16'h0001;
	// Timing: one millisecond of the 5 ns core clock.
	localparam int         FRS_CLK_PERIOD_PS     = 5000;
	localparam int         FRS_MS_PS             = 1000000000;
	localparam int         FRS_CYC_PER_MS        = FRS_MS_PS / FRS_CLK_PERIOD_PS;
	localparam int         FRS_TMR_W             = 24;

	typedef enum logic [2:0] {
		FRS_OFF, FRS_DELAY, FRS_RISE, FRS_ON, FRS_RUN_ON, FRS_WAIT_RETRY, FRS_LATCHED
	} frs_state_e;
endpackage

// ==== design/frs_tmr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface frs_tmr_if;
	logic                       start;
	logic [frs_pkg::FRS_TMR_W-1:0] ms_count;
	logic                       done;
	logic                       busy;
	modport ctl (output start, output ms_count, input done, input busy);
	modport tmr (input start, input ms_count, output done, output busy);
endinterface
`default_nettype wire

// ==== design/frs_ms_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module frs_ms_timer
	import frs_pkg::*;
#(
	parameter int CYC_PER_MS = FRS_CYC_PER_MS
) (
	input  wire logic   core_clk,
	input  wire logic   rst_b,
	frs_tmr_if.tmr      t
);
	logic [31:0]          pre_reg;
	logic [FRS_TMR_W-1:0] cnt_reg;
	logic                 run_reg;
	logic                 done_reg;
	wire                  pre_wrap = (pre_reg == 32'(CYC_PER_MS - 1));

	// A fresh start restarts the count even while running.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_reg  <= 32'h0;
			cnt_reg  <= '0;
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (t.start) begin
				pre_reg <= 32'h0;
				cnt_reg <= t.ms_count;
				run_reg <= 1'b1;
			end else if (run_reg) begin
				if (cnt_reg == '0) begin
					run_reg  <= 1'b0;
					done_reg <= 1'b1;
				end else if (pre_wrap) begin
					pre_reg <= 32'h0;
					cnt_reg <= cnt_reg - 1'b1;
				end else begin
					pre_reg <= pre_reg + 32'h1;
				end
			end
		end
	end

	assign t.done = done_reg;
	assign t.busy = run_reg;
endmodule
`default_nettype wire

// ==== design/frs_seq_ctrl.sv ====
//Contract
// RULE1 - Retry codes 4, 5, 6 restart that often, then latch output off.
// RULE2 - Retry code 7 restarts without limit until off command or other shutdown.
// RULE3 - Restart spacing is the unit count times the configured time unit.
// RULE4 - Units field codes 0,2..7 give 1,4,8,16,32,64,128 units.
// RULE5 - Same unit count sets run-on time before retry policy applies.
// RULE6 - One time unit comes from the register at command code 0xD2.
// RULE7 - Sixteen-bit assert threshold; good indication rises when output reaches it.
// RULE8 - Below negate threshold set good status bit, negate pin if enabled.
// RULE9 - Wait the programmable millisecond delay from enable before ramping.
// RULE10 - Ramp the output over the programmable millisecond rise time.
// RULE11 - Too long bringing output up without reaching undervoltage limit is timeout.
// RULE12 - A zero timeout limit disables the turn-on timeout.
// RULE13 - Response field: ignore, run on then retry, disable and retry, latch.
// RULE14 - Retry code 0 latches off; codes 1, 2, 3 restart that often.
// RULE15 - Latched fault clears by bit clear, clear command, reset, off-on, bias loss.
// RULE16 - Units field code 1 gives two units.
`timescale 1ns/1ps
`default_nettype none
module frs_seq_ctrl
	import frs_pkg::*;
#(
	parameter int CYC_PER_MS = FRS_CYC_PER_MS
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_wr,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic        cmd_rd,
	output logic      [15:0] cmd_rdata,
	input  wire logic        run_enable,
	input  wire logic        in_uv_fault,
	input  wire logic        out_uv_reached,
	input  wire logic [15:0] vout_level,
	input  wire logic        shared_pin_setup,
	input  wire logic        clear_faults,
	input  wire logic        clear_fault_bit,
	output logic             output_on,
	output logic             ramp_active,
	output logic             output_good_indicator,
	output logic             good_status_bit,
	output logic             fault_latched,
	output logic             turn_on_timeout
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] frs_units(input logic [2:0] code);
		frs_units = (code == 3'h0) ? 8'h01 : 8'(8'h01 << code); // RULE4 RULE16
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]  policy_reg;
	logic [15:0] pg_on_reg, pg_off_reg, turn_on_delay_reg, turn_on_rise_time_reg, ton_limit_reg, unit_reg;
	logic [15:0] rdata_reg;
	logic [15:0] rd_mux;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			policy_reg    <= FRS_RST_POLICY;
			pg_on_reg     <= FRS_RST_WORD;
			pg_off_reg    <= FRS_RST_WORD;
			turn_on_delay_reg <= FRS_RST_WORD;
			turn_on_rise_time_reg  <= FRS_RST_WORD;
			ton_limit_reg <= FRS_RST_WORD;
			unit_reg      <= FRS_RST_TIME_UNIT;
		end else if (cmd_wr) begin
			unique case (cmd_code)
				FRS_CMD_IN_UV_POLICY: policy_reg    <= cmd_wdata[7:0];
				FRS_CMD_PG_ASSERT:    pg_on_reg     <= cmd_wdata;
				FRS_CMD_PG_NEGATE:    pg_off_reg    <= cmd_wdata;
				FRS_CMD_TURN_ON_DELAY:    turn_on_delay_reg <= cmd_wdata;
				FRS_CMD_TURN_ON_RISE_TIME:     turn_on_rise_time_reg  <= cmd_wdata;
				FRS_CMD_TON_LIMIT:    ton_limit_reg <= cmd_wdata;
				FRS_CMD_TIME_UNIT:    unit_reg      <= cmd_wdata; // RULE6
				default: ;
			endcase
		end
	end

	always_comb begin
		unique case (cmd_code)
			FRS_CMD_IN_UV_POLICY: rd_mux = {8'h00, policy_reg};
			FRS_CMD_PG_ASSERT:    rd_mux = pg_on_reg;
			FRS_CMD_PG_NEGATE:    rd_mux = pg_off_reg;
			FRS_CMD_TURN_ON_DELAY:    rd_mux = turn_on_delay_reg;
			FRS_CMD_TURN_ON_RISE_TIME:     rd_mux = turn_on_rise_time_reg;
			FRS_CMD_TON_LIMIT:    rd_mux = ton_limit_reg;
			FRS_CMD_TIME_UNIT:    rd_mux = unit_reg;
			default:              rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			rdata_reg <= 16'h0000;
		else if (cmd_rd)
			rdata_reg <= rd_mux;
	end
	assign cmd_rdata = rdata_reg;

	// ----------------------------------------------------------------
	// Policy decode
	// ----------------------------------------------------------------
	wire [1:0] resp     = policy_reg[FRS_RESP_MSB:FRS_RESP_LSB];
	wire [2:0] retries  = policy_reg[FRS_RETRY_MSB:FRS_RETRY_LSB];
	wire [2:0] ucode    = policy_reg[FRS_UNITS_MSB:FRS_UNITS_LSB];
	wire [FRS_TMR_W-1:0] wait_ms = FRS_TMR_W'(frs_units(ucode) * unit_reg); // RULE3 RULE5

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	frs_state_e  state_reg, state_next;
	logic [2:0]  tries_reg, tries_next;
	logic        fault_stat_reg, timeout_reg;
	logic        pg_reg;
	logic [31:0] ton_pre_reg;
	logic [15:0] ton_ms_reg;
	frs_tmr_if   tmr ();

	wire enable_drop = !run_enable;
	// Commanding the output off clears the sticky flags as well, so an off-on cycle clears.
	wire fault_clear = clear_faults | clear_fault_bit | enable_drop; // RULE15
	wire powering    = (state_reg == FRS_DELAY) || (state_reg == FRS_RISE) ||
	                   (state_reg == FRS_ON);
	wire hit_limit   = (ton_limit_reg != 16'h0000) && (ton_ms_reg >= ton_limit_reg); // RULE12
	wire ton_fault   = powering && !out_uv_reached && hit_limit; // RULE11
	wire live_fault  = (state_reg == FRS_RISE || state_reg == FRS_ON) && in_uv_fault;
	// Retry limit: code 7 never runs out.
	wire retry_left  = (retries == FRS_RETRY_FOREVER) || (tries_reg < retries); // RULE1 RULE2 RULE14

	// Retry decision shared by the disable and run-on paths.
	function automatic frs_state_e frs_retry_pick(input logic left);
		frs_retry_pick = left ? FRS_WAIT_RETRY : FRS_LATCHED;
	endfunction

	always_comb begin
		state_next   = state_reg;
		tries_next   = tries_reg;
		tmr.start    = 1'b0;
		tmr.ms_count = '0;
		if (enable_drop) begin
			state_next = FRS_OFF; // RULE2 RULE15
		end else if (ton_fault) begin
			state_next = FRS_LATCHED;
		end else begin
			unique case (state_reg)
				FRS_OFF: begin
					state_next   = FRS_DELAY; // RULE9
					tries_next   = 3'h0;
					tmr.start    = 1'b1;
					tmr.ms_count = FRS_TMR_W'(turn_on_delay_reg);
				end
				FRS_DELAY: if (tmr.done) begin
					state_next   = FRS_RISE; // RULE10
					tmr.start    = 1'b1;
					tmr.ms_count = FRS_TMR_W'(turn_on_rise_time_reg);
				end
				FRS_RISE, FRS_ON: begin
					if (live_fault && resp == FRS_RESP_RUN_ON) begin
						state_next   = FRS_RUN_ON; // RULE13 RULE5
						tmr.start    = 1'b1;
						tmr.ms_count = wait_ms;
					end else if (live_fault && resp == FRS_RESP_DISABLE) begin
						state_next = frs_retry_pick(retry_left); // RULE13
					end else if (live_fault && resp == FRS_RESP_LATCH) begin
						state_next = FRS_LATCHED; // RULE13
					end else if (state_reg == FRS_RISE && tmr.done) begin
						state_next = FRS_ON;
					end
					if (state_next == FRS_WAIT_RETRY) begin
						tries_next   = tries_reg + 3'h1;
						tmr.start    = 1'b1;
						tmr.ms_count = wait_ms; // RULE3
					end
				end
				FRS_RUN_ON: if (tmr.done) begin
					if (!in_uv_fault) begin
						state_next = FRS_ON;
					end else begin
						state_next = frs_retry_pick(retry_left);
						if (retry_left) begin
							tries_next   = tries_reg + 3'h1;
							tmr.start    = 1'b1;
							tmr.ms_count = wait_ms;
						end
					end
				end
				FRS_WAIT_RETRY: if (tmr.done) begin
					state_next   = FRS_DELAY;
					tmr.start    = 1'b1;
					tmr.ms_count = FRS_TMR_W'(turn_on_delay_reg);
				end
				FRS_LATCHED: if (fault_clear) state_next = FRS_OFF; // RULE15
				default: state_next = FRS_OFF;
			endcase
		end
	end

	frs_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.t        (tmr.tmr)
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= FRS_OFF;
			tries_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			tries_reg <= tries_next;
		end
	end

	// Turn-on time counted in delay, rise and on while out_uv_reached is low; cleared otherwise.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ton_pre_reg <= 32'h0;
			ton_ms_reg  <= 16'h0000;
		end else if (!powering || out_uv_reached) begin
			ton_pre_reg <= 32'h0;
			ton_ms_reg  <= 16'h0000;
		end else if (ton_pre_reg == 32'(CYC_PER_MS - 1)) begin
			ton_pre_reg <= 32'h0;
			if (ton_ms_reg != 16'hFFFF)
				ton_ms_reg <= ton_ms_reg + 16'h0001;
		end else begin
			ton_pre_reg <= ton_pre_reg + 32'h1;
		end
	end

	// A new fault in the clearing cycle keeps its flag set.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_stat_reg <= 1'b0;
			timeout_reg    <= 1'b0;
		end else begin
			fault_stat_reg <= (live_fault && resp != FRS_RESP_IGNORE) ||
			                  (fault_stat_reg && !fault_clear); // RULE15
			timeout_reg    <= ton_fault || (timeout_reg && !fault_clear); // RULE11
		end
	end

	// ----------------------------------------------------------------
	// Power good
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			pg_reg <= 1'b0;
		else if (!output_on || vout_level < pg_off_reg)
			pg_reg <= 1'b0; // RULE8
		else if (vout_level >= pg_on_reg)
			pg_reg <= 1'b1; // RULE7
	end

	assign good_status_bit       = !pg_reg; // RULE8
	assign output_good_indicator = pg_reg && shared_pin_setup; // RULE8
	assign output_on   = (state_reg == FRS_RISE) || (state_reg == FRS_ON) ||
	                     (state_reg == FRS_RUN_ON);
	assign ramp_active = (state_reg == FRS_RISE);
	assign fault_latched   = fault_stat_reg || (state_reg == FRS_LATCHED);
	assign turn_on_timeout = timeout_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_fault_on;
		run_enable && !ton_fault && live_fault;
	endsequence
	sequence s_retry_out;
		s_fault_on and (resp == FRS_RESP_DISABLE);
	endsequence

	property p_limit_latch;
		s_retry_out and (retries != FRS_RETRY_FOREVER && tries_reg >= retries)
			|=> state_reg == FRS_LATCHED && !output_on;
	endproperty
	a_limit_latch: assert property (p_limit_latch) else $error("retry limit not latched"); // RULE1

	property p_forever;
		s_retry_out and (retries == FRS_RETRY_FOREVER) |=> state_reg == FRS_WAIT_RETRY;
	endproperty
	a_forever: assert property (p_forever) else $error("endless retry stopped"); // RULE2

	property p_wait_len;
		tmr.start && state_next == FRS_WAIT_RETRY |->
			tmr.ms_count == FRS_TMR_W'(frs_units(ucode) * unit_reg);
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("retry wait length wrong"); // RULE3

	property p_unit_one;
		frs_units(3'h1) == 8'h02 && frs_units(3'h7) == 8'h80;
	endproperty
	a_unit_one: assert property (p_unit_one) else $error("unit table wrong"); // RULE16

	property p_ignore;
		s_fault_on and (resp == FRS_RESP_IGNORE) |=> output_on;
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored fault stopped output"); // RULE13

	property p_no_retry;
		s_retry_out and (retries == FRS_RETRY_NONE) |=> state_reg == FRS_LATCHED;
	endproperty
	a_no_retry: assert property (p_no_retry) else $error("zero retries restarted"); // RULE14

	property p_pg_drop;
		pg_reg && vout_level < pg_off_reg |=> good_status_bit && !output_good_indicator;
	endproperty
	a_pg_drop: assert property (p_pg_drop) else $error("good not negated"); // RULE8

	property p_zero_limit;
		ton_limit_reg == 16'h0000 |-> !ton_fault;
	endproperty
	a_zero_limit: assert property (p_zero_limit) else $error("timeout with zero limit"); // RULE12

	property p_delay_start;
		state_reg == FRS_OFF && run_enable |=> (state_reg == FRS_DELAY && !output_on) [*2];
	endproperty
	a_delay_start: assert property (p_delay_start) else $error("ramp began without delay"); // RULE9

	property p_latch_hold;
		state_reg == FRS_LATCHED && run_enable && !fault_clear |=> state_reg == FRS_LATCHED;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched state left"); // RULE15
endmodule
`default_nettype wire

// ==== tb/frs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module frs_host_model (
	input  wire logic        core_clk,
	output logic      [7:0]  cmd_code,
	output logic             cmd_wr,
	output logic      [15:0] cmd_wdata,
	output logic             cmd_rd,
	output logic             clear_faults,
	output logic             clear_fault_bit
);
	// ----------------------------------------
	// Command access as seen from the host
	// ----------------------------------------
	initial begin
		cmd_code = 8'h00;
		cmd_wr = 1'b0;
		cmd_wdata = 16'h0000;
		cmd_rd = 1'b0;
		clear_faults = 1'b0;
		clear_fault_bit = 1'b0;
	end

	// Data is inverted once released so a design that samples late sees garbage.
	task automatic access(input logic [7:0] code, input logic wr, input logic [15:0] d);
		@(posedge core_clk);
		cmd_code <= code;
		cmd_wr <= wr;
		cmd_rd <= !wr;
		cmd_wdata <= d;
		@(posedge core_clk);
		cmd_wr <= 1'b0;
		cmd_rd <= 1'b0;
		cmd_wdata <= ~d;
	endtask

	task automatic clear(input logic bit_only);
		@(posedge core_clk);
		clear_faults <= !bit_only;
		clear_fault_bit <= bit_only;
		@(posedge core_clk);
		clear_faults <= 1'b0;
		clear_fault_bit <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import frs_pkg::*;
	localparam int C = 4;
	localparam logic [7:0] CODES [7] = '{FRS_CMD_IN_UV_POLICY, FRS_CMD_PG_ASSERT,
		FRS_CMD_PG_NEGATE, FRS_CMD_TURN_ON_DELAY, FRS_CMD_TURN_ON_RISE_TIME, FRS_CMD_TON_LIMIT,
		FRS_CMD_TIME_UNIT};
	localparam int UNITS [8] = '{1, 2, 4, 8, 16, 32, 64, 128};
	logic        core_clk;
	logic        rst_b;
	logic [7:0]  cmd_code;
	logic        cmd_wr;
	logic [15:0] cmd_wdata;
	logic        cmd_rd;
	logic [15:0] cmd_rdata;
	logic        run_enable;
	logic        in_uv_fault;
	logic        out_uv_reached;
	logic [15:0] vout_level;
	logic        shared_pin_setup;
	logic        clear_faults;
	logic        clear_fault_bit;
	logic        output_on;
	logic        ramp_active;
	logic        output_good_indicator;
	logic        good_status_bit;
	logic        fault_latched;
	logic        turn_on_timeout;
	int          mismatches = 0;
	int          n_compared = 0;
	logic [15:0] exp_q [$];
	logic        rd_d = 1'b0;

	frs_seq_ctrl #(.CYC_PER_MS(C)) dut_u (.core_clk, .rst_b, .cmd_code, .cmd_wr,
		.cmd_wdata, .cmd_rd, .cmd_rdata, .run_enable, .in_uv_fault, .out_uv_reached,
		.vout_level, .shared_pin_setup, .clear_faults, .clear_fault_bit, .output_on,
		.ramp_active, .output_good_indicator, .good_status_bit, .fault_latched,
		.turn_on_timeout);
	frs_host_model host_u (.core_clk, .cmd_code, .cmd_wr, .cmd_wdata, .cmd_rd,
		.clear_faults, .clear_fault_bit);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// Checking and access tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Read data lands one cycle after the strobe, so the note is taken then.
	always @(posedge core_clk) begin
		if (rd_d === 1'b1 && exp_q.size() > 0) check(cmd_rdata, exp_q.pop_front());
		rd_d <= cmd_rd;
	end

	task automatic wr(input logic [7:0] code, input logic [15:0] d);
		host_u.access(code, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] code, input logic [15:0] e);
		exp_q.push_back(e);
		host_u.access(code, 1'b0, 16'h0000);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	function automatic logic pick(input int which);
		return which == 0 ? output_on : which == 1 ? ramp_active : turn_on_timeout;
	endfunction

	task automatic wait_for(input int which, input logic lvl, output int n);
		n = 0;
		while (pick(which) !== lvl && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	// The sticky fault flag rises at the first fault, so the end of retrying is
	// recognised by the output staying off far longer than one retry wait.
	task automatic count_tries(output int tries);
		int n;
		int idle;
		logic prev;
		tries = 0;
		n = 0;
		idle = 0;
		prev = output_on;
		while (idle < 40 && n < 3000) begin
			@(posedge core_clk);
			if (output_on === 1'b1 && prev !== 1'b1) tries++;
			idle = (output_on === 1'b1) ? 0 : idle + 1;
			prev = output_on;
			n++;
		end
	endtask

	initial begin
		#300000;
		mismatches++;
		conclude();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int n;
		int t;
		logic [15:0] a;
		logic [15:0] v;
		void'($urandom(32'h4D8B));
		rst_b = 1'b0;
		run_enable = 1'b0;
		in_uv_fault = 1'b0;
		out_uv_reached = 1'b1;
		vout_level = 16'h0000;
		shared_pin_setup = 1'b0;
		cyc(8);
		rst_b <= 1'b1;
		cyc(1);
		check(good_status_bit, 1'b1);
		foreach (CODES[i]) rd(CODES[i], i == 0 ? {8'h00, FRS_RST_POLICY} :
			i == 6 ? FRS_RST_TIME_UNIT : FRS_RST_WORD);
		foreach (CODES[i]) begin
			v = 16'($urandom);
			wr(CODES[i], v);
			rd(CODES[i], i == 0 ? {8'h00, v[7:0]} : v);
		end
		wr(8'h00, 16'hFFFF);
		rd(8'h00, 16'h0000);
		wr(FRS_CMD_TIME_UNIT, 16'h0001);
		wr(FRS_CMD_TURN_ON_DELAY, 16'h0003);
		wr(FRS_CMD_TURN_ON_RISE_TIME, 16'h0002);
		wr(FRS_CMD_TON_LIMIT, 16'h0000);
		wr(FRS_CMD_IN_UV_POLICY, 16'h0000);
		a = 16'h1000 + 16'($urandom_range(16'hE000));
		wr(FRS_CMD_PG_ASSERT, a);
		wr(FRS_CMD_PG_NEGATE, a - 16'h0100);
		shared_pin_setup <= 1'($urandom);
		vout_level <= a - 16'h0001;
		run_enable <= 1'b1;
		wait_for(0, 1'b1, n);
		check(n >= 3 * C && n <= 3 * C + 6, 1'b1);
		wait_for(1, 1'b0, n);
		check(n >= 2 * C && n <= 2 * C + 6, 1'b1);
		check(good_status_bit, 1'b1);
		vout_level <= a;
		cyc(3);
		check(good_status_bit, 1'b0);
		check(output_good_indicator, shared_pin_setup);
		vout_level <= a - 16'h0100;
		cyc(3);
		check(good_status_bit, 1'b0);
		vout_level <= a - 16'h0101;
		in_uv_fault <= 1'b1;
		cyc(40);
		check(good_status_bit, 1'b1);
		check(output_good_indicator, 1'b0);
		check(output_on, 1'b1);
		wr(FRS_CMD_IN_UV_POLICY, 16'h0042);
		wait_for(0, 1'b0, n);
		check(n >= 4 * C && n <= 4 * C + 8, 1'b1);
		check(fault_latched, 1'b1);
		in_uv_fault <= 1'b0;
		host_u.clear(1'b1);
		wait_for(0, 1'b1, n);
		check(fault_latched, 1'b0);
		out_uv_reached <= 1'b0;
		cyc(200);
		check(turn_on_timeout, 1'b0);
		run_enable <= 1'b0;
		wr(FRS_CMD_TON_LIMIT, 16'h0003);
		run_enable <= 1'b1;
		wait_for(2, 1'b1, n);
		check(n >= 3 * C && n <= 3 * C + 6, 1'b1);
		check(output_on, 1'b0);
		run_enable <= 1'b0;
		out_uv_reached <= 1'b1;
		host_u.clear(1'b0);
		wr(FRS_CMD_TON_LIMIT, 16'h0000);
		wr(FRS_CMD_TURN_ON_DELAY, 16'h0000);
		wr(FRS_CMD_TURN_ON_RISE_TIME, 16'h0001);
		for (int k = 0; k < 8; k++) begin
			wr(FRS_CMD_IN_UV_POLICY, k == 7 ? 16'h00D8 : {8'h00, 2'b10, 3'(k), 3'b000});
			in_uv_fault <= 1'b1;
			run_enable <= 1'b1;
			count_tries(t);
			check(t, k == 7 ? 1 : k + 1);
			check(output_on, 1'b0);
			in_uv_fault <= 1'b0;
			if (k % 2 == 0) host_u.clear(k[1]);
			else run_enable <= 1'b0;
			cyc(3);
			check(fault_latched, 1'b0);
			run_enable <= 1'b0;
			cyc(2);
		end
		wr(FRS_CMD_TIME_UNIT, 16'h0002);
		for (int c = 0; c < 8; c++) begin
			wr(FRS_CMD_IN_UV_POLICY, {8'h00, 2'b10, 3'b111, 3'(c)});
			in_uv_fault <= 1'b1;
			run_enable <= 1'b1;
			repeat (3) begin
				wait_for(0, 1'b1, n);
				wait_for(0, 1'b0, n);
			end
			wait_for(0, 1'b1, n);
			check(n >= UNITS[c] * 2 * C && n <= UNITS[c] * 2 * C + 6, 1'b1);
			check(fault_latched, 1'b1);
			run_enable <= 1'b0;
			in_uv_fault <= 1'b0;
			cyc(3);
			check(output_on, 1'b0);
			check(fault_latched, 1'b0);
		end
		cyc(4);
		conclude();
	end
endmodule
`default_nettype wire
